// *** core/ttpc_pkg.sv ***
// shared constants and types for the triac phase-angle output stage
package ttpc_pkg;

  // system clock and mains timing
  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam int unsigned NCH            = 4;
  localparam int unsigned STEPS_PER_HALF = 200;
  localparam logic [7:0]  STEP_LAST      = 8'hC7;
  localparam int unsigned F_MIN_HZ       = 45;
  localparam int unsigned F_MAX_HZ       = 65;
  localparam int unsigned F_NOM_HZ       = 50;
  // shortest legal half period rounds up, longest rounds down
  localparam int unsigned HALF_MIN_CYC   = (CLK_HZ + 2 * F_MAX_HZ - 1) / (2 * F_MAX_HZ);
  localparam int unsigned HALF_MAX_CYC   = CLK_HZ / (2 * F_MIN_HZ);
  localparam int unsigned HALF_NOM_CYC   = CLK_HZ / (2 * F_NOM_HZ);
  localparam int unsigned OFF_PERIODS    = 3;
  localparam logic [3:0]  OFF_HALVES     = 4'(2 * OFF_PERIODS);
  localparam logic [3:0]  MEAS_PHASES    = 4'h4;
  localparam logic [3:0]  PAT_CYCLE_LAST = 4'hB;

  // configuration write offsets
  localparam logic [7:0]  ADR_SWOFF1     = 8'h14;
  localparam logic [7:0]  ADR_OUTCFG     = 8'h1C;
  localparam logic [7:0]  ADR_TOL        = 8'h1D;
  localparam logic [7:0]  ADR_PATTERN    = 8'h20;

  // reset values
  localparam logic [7:0]  RST_SWOFF      = 8'h05;
  localparam logic [7:0]  RST_OUTCFG     = 8'h0F;
  localparam logic [7:0]  RST_TOL        = 8'h00;
  localparam logic [15:0] RST_PATTERN    = 16'h0000;

  // field layout
  localparam int unsigned OUTCFG_HALF_LSB = 4;
  localparam int unsigned TOL_MODE_BIT    = 7;
  localparam logic [7:0]  TOL_WMASK       = 8'h9F;
  localparam logic [4:0]  TOL_CNT_MAX     = 5'h1E;
  localparam int unsigned PAT_W           = 4;

  // percent limits
  localparam logic [7:0]  SWOFF_MIN      = 8'h05;
  localparam logic [7:0]  SWOFF_MAX      = 8'h32;
  localparam logic [7:0]  ANA_PROP_MAX   = 8'h5F;
  localparam logic [7:0]  ANA_FULL       = 8'h64;

  // half-wave pattern codes
  localparam logic [3:0]  PAT_100        = 4'h0;
  localparam logic [3:0]  PAT_50         = 4'h1;
  localparam logic [3:0]  PAT_25         = 4'h2;
  localparam logic [3:0]  PAT_33         = 4'h3;
  localparam logic [3:0]  PAT_50_D1      = 4'h5;
  localparam logic [3:0]  PAT_25_D2      = 4'h6;
  localparam logic [3:0]  PAT_33_D1      = 4'h7;

  typedef enum logic [1:0] {SY_RUN, SY_OFF, SY_MEAS} ttpc_sync_t;

endpackage

// *** core/ttpc_tb_if.sv ***
// half-wave timebase shared from the sync core to the channels
`timescale 1ns/1ps
interface ttpc_tb_if;
  logic [7:0] step;
  logic       hw_start;
  logic       positive;
  logic       run;
  logic       freq_mode;
  logic [3:0] hw_idx;
  modport src (output step, output hw_start, output positive, output run,
               output freq_mode, output hw_idx);
  modport snk (input step, input hw_start, input positive, input run,
               input freq_mode, input hw_idx);
endinterface // ttpc_tb_if

// *** core/ttpc_pll.sv ***
// phase accumulator giving 200 steps per measured half period
`timescale 1ns/1ps
module ttpc_pll #(
  parameter int unsigned PW = 18
) (
  input  wire logic          clk,
  input  wire logic          resetn,
  input  wire logic [PW-1:0] period,
  input  wire logic          align,
  input  wire logic          free_run,
  output logic      [7:0]    step,
  output logic               wrap
);
  typedef struct packed {
    logic [PW:0] acc;
    logic [7:0]  step;
    logic        wrap;
  } ttpc_pll_st_t;

  ttpc_pll_st_t st_q;
  ttpc_pll_st_t st_d;

  // add 200 per clock, one step each time the period is passed
  always_comb begin
    logic [PW:0] sum;
    sum = st_q.acc + (PW+1)'(ttpc_pkg::STEPS_PER_HALF);
    st_d = st_q;
    st_d.wrap = 1'b0;
    if (align) begin
      st_d.acc  = '0;
      st_d.step = 8'h00;
    end else if (sum >= {1'b0, period}) begin
      st_d.acc = sum - {1'b0, period};
      if (st_q.step == ttpc_pkg::STEP_LAST) begin
        // held at the last step when the crossing itself closes the half
        if (free_run) begin
          st_d.step = 8'h00;
          st_d.wrap = 1'b1;
        end
      end else begin
        st_d.step = st_q.step + 8'h01;
      end
    end else begin
      st_d.acc = sum;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign step = st_q.step;
  assign wrap = st_q.wrap;

  property p_step_range;
    @(posedge clk) disable iff (!resetn) st_q.step <= ttpc_pkg::STEP_LAST;
  endproperty
  a_step_range: assert property (p_step_range) else $error("step beyond 199");
endmodule // ttpc_pll

// *** core/ttpc_chan.sv ***
// one triac channel: digital, phase-angle and pattern gating
`timescale 1ns/1ps
module ttpc_chan (
  input  wire logic       clk,
  input  wire logic       resetn,
  ttpc_tb_if.snk          tb,
  input  wire logic       analog_sel,
  input  wire logic       half_suppress,
  input  wire logic [7:0] angle,
  input  wire logic       dig_bit,
  input  wire logic [7:0] swoff,
  input  wire logic [3:0] pat_code,
  output logic            drive
);
  typedef struct packed {
    logic [7:0] ang;
    logic       dig_on;
    logic       drive;
  } ttpc_chan_st_t;

  ttpc_chan_st_t st_q;
  ttpc_chan_st_t st_d;
  logic [7:0]    sw;
  logic [7:0]    stop;
  logic [7:0]    start;
  logic          pat_hit;

  // clamp the lead to 5..50 percent; 1 percent is two steps
  always_comb begin
    sw = (swoff < ttpc_pkg::SWOFF_MIN) ? ttpc_pkg::SWOFF_MIN :
         (swoff > ttpc_pkg::SWOFF_MAX) ? ttpc_pkg::SWOFF_MAX : swoff;
    stop  = 8'((ttpc_pkg::ANA_FULL - sw) << 1);
    // above 95 percent the start is held back for open-line sensing
    start = (st_q.ang > ttpc_pkg::ANA_PROP_MAX) ?
            8'((ttpc_pkg::ANA_FULL - ttpc_pkg::ANA_PROP_MAX) << 1) :
            8'((ttpc_pkg::ANA_FULL - st_q.ang) << 1);
  end

  // pattern position within the 12-half-wave cycle
  always_comb begin
    unique case (pat_code)
      ttpc_pkg::PAT_50:    pat_hit = (tb.hw_idx % 4'h2) == 4'h0;
      ttpc_pkg::PAT_25:    pat_hit = (tb.hw_idx % 4'h4) == 4'h0;
      ttpc_pkg::PAT_33:    pat_hit = (tb.hw_idx % 4'h3) == 4'h0;
      ttpc_pkg::PAT_50_D1: pat_hit = (tb.hw_idx % 4'h2) == 4'h1;
      ttpc_pkg::PAT_25_D2: pat_hit = (tb.hw_idx % 4'h4) == 4'h2;
      ttpc_pkg::PAT_33_D1: pat_hit = (tb.hw_idx % 4'h3) == 4'h1;
      default:             pat_hit = 1'b1;
    endcase
  end

  // latch values at half-wave starts, then gate the drive
  always_comb begin
    logic ok;
    ok = tb.run && (tb.step < stop)
         && (tb.positive || !(half_suppress && !tb.freq_mode))
         && (!tb.freq_mode || pat_hit);
    st_d = st_q;
    if (tb.hw_start && tb.positive) begin
      st_d.ang = (angle > ttpc_pkg::ANA_FULL) ? ttpc_pkg::ANA_FULL : angle;
    end
    if (tb.hw_start) begin
      if (!dig_bit) begin
        st_d.dig_on = 1'b0;
      end else if (tb.positive) begin
        st_d.dig_on = 1'b1;
      end
    end
    if (analog_sel) begin
      st_d.drive = ok && (st_q.ang > sw) && (tb.step >= start);
    end else begin
      st_d.drive = ok && st_q.dig_on;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign drive = st_q.drive;

  property p_no_late_fire;
    @(posedge clk) disable iff (!resetn) drive |-> $past(tb.step) < $past(stop);
  endproperty
  a_no_late_fire: assert property (p_no_late_fire) else $error("fired after stop");
endmodule // ttpc_chan

// *** core/ttpc_top.sv ***
// four-channel mains-synchronous triac output configuration and timing
//
// Contract
// - pattern gating applies only in frequency mode; firing angle unchanged.
// - 16-bit pattern, 4 bits per channel; codes 0..3 give 100/50/25/33.
// - codes 5, 6, 7 give 50, 25, 33 with half-wave offsets 1, 2, 1.
// - per-channel lead of 5..50 percent sets the drive cut before crossing.
// - every lead setting resets to 5 percent.
// - never fire at or after the cut point of a half-wave.
// - setup bits 0..3 pick digital bit or analog angle per channel.
// - setup bits 4..7 suppress the negative half-wave per channel.
// - negative half-wave suppression is ignored in frequency mode.
// - channel setup resets to 15: all analog, full wave.
// - the commutation angle acts only on analog channels.
// - after the set error count, outputs off three periods, then resync.
// - policy bit 7 picks fast or PLL resync; whole register resets to 0.
// - fast mode realigns the trigger point at every zero crossing.
// - PLL mode averages intervals and measures extra phases before restart.
// - timebase of 200 steps per half-wave shared by all channels.
// - lost or short periods cut outputs and raise the dropout flag.
// - analog fires only above the lead, proportional to 95, new value on positive half.
// - digital on at positive voltage zero, off at any half-wave boundary with the bit low.
`timescale 1ns/1ps
module ttpc_top #(
  parameter int unsigned NCH          = ttpc_pkg::NCH,
  parameter int unsigned MIN_HALF_CYC = ttpc_pkg::HALF_MIN_CYC,
  parameter int unsigned MAX_HALF_CYC = ttpc_pkg::HALF_MAX_CYC,
  parameter int unsigned NOM_HALF_CYC = ttpc_pkg::HALF_NOM_CYC
) (
  input  wire logic                clk,
  input  wire logic                resetn,
  input  wire logic                cfg_wr_en,
  input  wire logic [7:0]          cfg_addr,
  input  wire logic [15:0]         cfg_wdata,
  input  wire logic                freq_mode,
  input  wire logic [NCH-1:0][7:0] commutation_angle_ch,
  input  wire logic [NCH-1:0]      switching_state_bits,
  input  wire logic                zero_cross_in,
  output logic      [NCH-1:0]      triac_drive,
  output logic                     zero_cross_dropout_flag,
  output logic                     zero_cross_polarity,
  output logic [7:0]               zero_cross_error_policy_rd
);
  localparam int unsigned PW = $clog2(MAX_HALF_CYC + 2);

  typedef struct packed {
    logic [15:0]          pattern;
    logic [NCH-1:0][7:0]  swoff;
    logic [7:0]           outcfg;
    logic [7:0]           tol;
    logic [2:0]           zc_sync;
    logic [PW-1:0]        iv_cnt;
    logic [PW-1:0]        period;
    logic [4:0]           err_cnt;
    logic [3:0]           halves;
    ttpc_pkg::ttpc_sync_t mode;
    logic                 dropout;
    logic [3:0]           hw_idx;
    logic                 positive;
    logic                 hw_start;
    logic                 align;
  } ttpc_top_st_t;

  ttpc_top_st_t  st_q;
  ttpc_top_st_t  st_d;
  ttpc_tb_if     tb ();
  logic [7:0]    step;
  logic          pll_wrap;
  logic          edge_seen;
  logic          short_iv;
  logic          timeout;
  logic          good_zc;
  logic          err_ev;
  logic          pll_mode;
  logic [4:0]    tol_lim;
  logic [PW-1:0] iv_len;

  // crossing qualification; an edge is the second and third sync stages differing
  always_comb begin
    edge_seen = st_q.zc_sync[1] ^ st_q.zc_sync[2];
    iv_len    = st_q.iv_cnt + PW'(1);
    short_iv  = edge_seen && (iv_len < PW'(MIN_HALF_CYC));
    timeout   = !edge_seen && (st_q.iv_cnt >= PW'(MAX_HALF_CYC));
    good_zc   = edge_seen && !short_iv;
    err_ev    = short_iv || timeout;
    pll_mode  = st_q.tol[ttpc_pkg::TOL_MODE_BIT];
    tol_lim   = (st_q.tol[4:0] > ttpc_pkg::TOL_CNT_MAX) ? ttpc_pkg::TOL_CNT_MAX
                                                        : st_q.tol[4:0];
  end

  // configuration writes and the sync supervisor
  always_comb begin
    st_d = st_q;
    st_d.hw_start = 1'b0;
    st_d.align    = 1'b0;
    st_d.zc_sync  = {st_q.zc_sync[1:0], zero_cross_in};
    if (cfg_wr_en) begin
      for (int i = 0; i < NCH; i++) begin
        if (cfg_addr == 8'(ttpc_pkg::ADR_SWOFF1 + 2 * i)) begin
          st_d.swoff[i] = cfg_wdata[7:0];
        end
      end
      if (cfg_addr == ttpc_pkg::ADR_OUTCFG) begin
        st_d.outcfg = cfg_wdata[7:0];
      end
      if (cfg_addr == ttpc_pkg::ADR_TOL) begin
        st_d.tol = cfg_wdata[7:0] & ttpc_pkg::TOL_WMASK;
      end
      if (cfg_addr == ttpc_pkg::ADR_PATTERN) begin
        st_d.pattern = cfg_wdata;
      end
    end
    // interval counter restarts at each crossing and on each timeout
    if (edge_seen || timeout) begin
      st_d.iv_cnt = '0;
    end else begin
      st_d.iv_cnt = iv_len;
    end
    // timebase: fast tracks each interval, PLL averages old and new
    if (good_zc) begin
      if (pll_mode) begin
        st_d.period = PW'(({1'b0, st_q.period} + {1'b0, iv_len}) >> 1);
      end else begin
        st_d.period = iv_len;
      end
    end
    unique case (st_q.mode)
      ttpc_pkg::SY_RUN: begin
        if (err_ev) begin
          if (st_q.err_cnt >= tol_lim) begin
            st_d.mode    = ttpc_pkg::SY_OFF;
            st_d.dropout = 1'b1;
            st_d.halves  = 4'h0;
            st_d.err_cnt = 5'h00;
          end else begin
            st_d.err_cnt = st_q.err_cnt + 5'h01;
          end
        end else if (!pll_mode && good_zc) begin
          st_d.align    = 1'b1;
          st_d.hw_start = 1'b1;
          st_d.positive = st_q.zc_sync[1];
        end else if (pll_mode && pll_wrap) begin
          // free running half-waves between measured crossings
          st_d.hw_start = 1'b1;
          st_d.positive = !st_q.positive;
        end
      end
      ttpc_pkg::SY_OFF: begin
        // outputs stay off for at least three whole mains periods
        if (err_ev) begin
          st_d.halves = 4'h0;
        end else if (good_zc) begin
          if (st_q.halves == ttpc_pkg::OFF_HALVES - 4'h1) begin
            st_d.halves = 4'h0;
            if (pll_mode) begin
              st_d.mode = ttpc_pkg::SY_MEAS;
            end else begin
              st_d.mode     = ttpc_pkg::SY_RUN;
              st_d.dropout  = 1'b0;
              st_d.align    = 1'b1;
              st_d.hw_start = 1'b1;
              st_d.positive = st_q.zc_sync[1];
            end
          end else begin
            st_d.halves = st_q.halves + 4'h1;
          end
        end
      end
      ttpc_pkg::SY_MEAS: begin
        // extra measured intervals settle the average before restart
        if (err_ev) begin
          st_d.mode   = ttpc_pkg::SY_OFF;
          st_d.halves = 4'h0;
        end else if (good_zc) begin
          if (st_q.halves == ttpc_pkg::MEAS_PHASES - 4'h1) begin
            st_d.mode     = ttpc_pkg::SY_RUN;
            st_d.dropout  = 1'b0;
            st_d.halves   = 4'h0;
            st_d.align    = 1'b1;
            st_d.hw_start = 1'b1;
            st_d.positive = st_q.zc_sync[1];
          end else begin
            st_d.halves = st_q.halves + 4'h1;
          end
        end
      end
      default: begin
        st_d.mode = ttpc_pkg::SY_OFF;
      end
    endcase
    // 12 half-waves hold every pattern period of 2, 3 and 4
    if (st_d.hw_start) begin
      st_d.hw_idx = (st_q.hw_idx == ttpc_pkg::PAT_CYCLE_LAST) ? 4'h0
                                                              : st_q.hw_idx + 4'h1;
    end
  end

  // startup waits out three periods just like a trip
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_q.pattern  <= ttpc_pkg::RST_PATTERN;
      st_q.swoff    <= {NCH{ttpc_pkg::RST_SWOFF}};
      st_q.outcfg   <= ttpc_pkg::RST_OUTCFG;
      st_q.tol      <= ttpc_pkg::RST_TOL;
      st_q.zc_sync  <= 3'h0;
      st_q.iv_cnt   <= '0;
      st_q.period   <= PW'(NOM_HALF_CYC);
      st_q.err_cnt  <= 5'h00;
      st_q.halves   <= 4'h0;
      st_q.mode     <= ttpc_pkg::SY_OFF;
      st_q.dropout  <= 1'b0;
      st_q.hw_idx   <= 4'h0;
      st_q.positive <= 1'b0;
      st_q.hw_start <= 1'b0;
      st_q.align    <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // shared 200-step timebase
  ttpc_pll #(
    .PW       (PW)
  ) u_pll (
    .clk      (clk),
    .resetn   (resetn),
    .period   (st_q.period),
    .align    (st_q.align),
    .free_run (pll_mode),
    .step     (step),
    .wrap     (pll_wrap)
  );

  // timebase fan-out to the channels
  assign tb.step      = step;
  assign tb.hw_start  = st_q.hw_start;
  assign tb.positive  = st_q.positive;
  assign tb.run       = (st_q.mode == ttpc_pkg::SY_RUN);
  assign tb.freq_mode = freq_mode;
  assign tb.hw_idx    = st_q.hw_idx;

  for (genvar c = 0; c < NCH; c++) begin : g_chan
    ttpc_chan u_chan (
      .clk           (clk),
      .resetn        (resetn),
      .tb            (tb),
      .analog_sel    (st_q.outcfg[c]),
      .half_suppress (st_q.outcfg[ttpc_pkg::OUTCFG_HALF_LSB + c]),
      .angle         (commutation_angle_ch[c]),
      .dig_bit       (switching_state_bits[c]),
      .swoff         (st_q.swoff[c]),
      .pat_code      (st_q.pattern[c*ttpc_pkg::PAT_W +: ttpc_pkg::PAT_W]),
      .drive         (triac_drive[c])
    );
  end

  assign zero_cross_dropout_flag    = st_q.dropout;
  assign zero_cross_polarity        = st_q.positive;
  assign zero_cross_error_policy_rd = st_q.tol;

  property p_reset_values;
    @(posedge clk) !resetn |=> (st_q.swoff == {NCH{ttpc_pkg::RST_SWOFF}})
      && (st_q.outcfg == ttpc_pkg::RST_OUTCFG) && (st_q.tol == ttpc_pkg::RST_TOL);
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("bad reset value");

  property p_reserved_zero;
    @(posedge clk) disable iff (!resetn) zero_cross_error_policy_rd[6:5] == 2'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

  property p_cut_when_off;
    @(posedge clk) disable iff (!resetn) (st_q.mode != ttpc_pkg::SY_RUN) |=> triac_drive == '0;
  endproperty
  a_cut_when_off: assert property (p_cut_when_off) else $error("drive while not synced");

  property p_off_min_time;
    @(posedge clk) disable iff (!resetn)
      ($past(st_q.mode) == ttpc_pkg::SY_OFF) && (st_q.mode != ttpc_pkg::SY_OFF)
      |-> $past(st_q.halves) == ttpc_pkg::OFF_HALVES - 4'h1;
  endproperty
  a_off_min_time: assert property (p_off_min_time) else $error("left off state early");

  property p_trip_sets_flag;
    @(posedge clk) disable iff (!resetn)
      (st_q.mode == ttpc_pkg::SY_RUN) && err_ev && (st_q.err_cnt >= tol_lim)
      |=> zero_cross_dropout_flag && (st_q.mode == ttpc_pkg::SY_OFF);
  endproperty
  a_trip_sets_flag: assert property (p_trip_sets_flag) else $error("trip not taken");

  property p_fast_realign;
    @(posedge clk) disable iff (!resetn)
      (st_q.mode == ttpc_pkg::SY_RUN) && !pll_mode && good_zc
      |=> st_q.hw_start ##1 (step == 8'h00);
  endproperty
  a_fast_realign: assert property (p_fast_realign) else $error("no realign at crossing");

  property p_pll_measures;
    @(posedge clk) disable iff (!resetn)
      ($past(st_q.mode) == ttpc_pkg::SY_OFF) && (st_q.mode == ttpc_pkg::SY_RUN) |-> !pll_mode;
  endproperty
  a_pll_measures: assert property (p_pll_measures) else $error("pll skipped measuring");

  property p_pll_average;
    @(posedge clk) disable iff (!resetn)
      good_zc && pll_mode && $stable(pll_mode)
      |=> st_q.period == PW'(({1'b0, $past(st_q.period)} + {1'b0, $past(iv_len)}) >> 1);
  endproperty
  a_pll_average: assert property (p_pll_average) else $error("period not averaged");

  property p_pattern_off;
    @(posedge clk) disable iff (!resetn)
      freq_mode && (st_q.pattern[7:4] == ttpc_pkg::PAT_50) && st_q.hw_idx[0]
      |=> !triac_drive[1];
  endproperty
  a_pattern_off: assert property (p_pattern_off) else $error("pattern skip fired");

  property p_half_suppress;
    @(posedge clk) disable iff (!resetn)
      !freq_mode && st_q.outcfg[ttpc_pkg::OUTCFG_HALF_LSB] && !st_q.positive
      |=> !triac_drive[0];
  endproperty
  a_half_suppress: assert property (p_half_suppress) else $error("negative half fired");
endmodule // ttpc_top

// *** dv/ttpc_zc_model.sv ***
// zero-crossing detector model: one level change per half-wave
`timescale 1ns/1ps
module ttpc_zc_model #(
  parameter int unsigned HALF = 1000
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic en,
  output logic      zc
);
  int unsigned cnt_q;

  // mains lost when en is low: the detector holds its level, no edges
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt_q <= 0;
      zc    <= 1'b0;
    end else if (en) begin
      if (cnt_q == HALF - 1) begin
        cnt_q <= 0;
        zc    <= ~zc;
      end else begin
        cnt_q <= cnt_q + 1;
      end
    end
  end
endmodule // ttpc_zc_model

// *** dv/tb.sv ***
// self-checking bench for the triac output configuration stage
`timescale 1ns/1ps
module tb;
  logic            clk, resetn, cfg_wr_en, freq_mode, zc_en, zc, drop, pol;
  logic [7:0]      cfg_addr, pol_rd;
  logic [15:0]     cfg_wdata;
  logic [3:0][7:0] angle;
  logic [3:0]      dig, drive;
  int              errors, checks, ov;
  int              cnt [4];
  int              expc [2][4] = '{'{12, 6, 4, 6}, '{3, 4, 3, 4}};
  logic [15:0]     pat [2] = '{16'h5310, 16'h7632};

  // half period scaled to 1000 clocks to keep the run short
  ttpc_top #(.MIN_HALF_CYC(700), .MAX_HALF_CYC(1300), .NOM_HALF_CYC(1000)) i_dut (
    .clk(clk), .resetn(resetn), .cfg_wr_en(cfg_wr_en), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .freq_mode(freq_mode), .commutation_angle_ch(angle),
    .switching_state_bits(dig), .zero_cross_in(zc), .triac_drive(drive),
    .zero_cross_dropout_flag(drop), .zero_cross_polarity(pol),
    .zero_cross_error_policy_rd(pol_rd));
  ttpc_zc_model #(.HALF(1000)) i_zc (.clk(clk), .resetn(resetn), .en(zc_en), .zc(zc));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // one write strobe, dropped after the storing edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    wait_clk(1);
    cfg_wr_en = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    wait_clk(1);
    cfg_wr_en = 1'b0;
  endtask

  // wait for the next crossing, bounded, then n clocks into the half
  task automatic half(input int n);
    logic z;
    z = zc;
    for (int i = 0; i < 3000 && zc === z; i++) @(posedge clk);
    wait_clk(n);
  endtask

  // cut the mains, then bring it back and watch the resync delay
  task automatic trip(input logic [7:0] m, input int k);
    wr(8'h1D, {8'h00, m});
    zc_en = 1'b0;
    wait_clk(1000);
    chk("dropout", 16'h0001, {15'h0, drop});
    chk("drive_cut", 16'h0000, {12'h0, drive});
    zc_en = 1'b1;
    repeat (k) half(0);
    chk("dropout_hold", 16'h0001, {15'h0, drop});
    repeat (6) half(0);
    half(500);
    chk("dropout_clear", 16'h0000, {15'h0, drop});
    if (m == 8'h00) chk("drive_resync", 16'h000F, {12'h0, drive});
  endtask

  task automatic report_and_stop();
    if (errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // watchdog: the whole sequence needs about 75000 clocks
  initial begin
    #(95000 * 50);
    errors++;
    report_and_stop();
  end

  initial begin
    {cfg_wr_en, cfg_addr, cfg_wdata, freq_mode, dig, zc_en, resetn} = '0;
    angle = {8'h03, 8'h64, 8'h64, 8'h64};
    errors = 0;
    checks = 0;
    wait_clk(2);
    resetn = 1'b1;
    chk("policy_rst", 16'h0000, {8'h0, pol_rd});
    zc_en = 1'b1;
    wr(8'h1D, 16'h00FF);
    chk("policy_rsvd", 16'h009F, {8'h0, pol_rd});
    wr(8'h1D, 16'h0000);
    wr(8'h55, 16'h00FF);
    chk("policy_unmapped", 16'h0000, {8'h0, pol_rd});
    // default setup: analog, lead 5, low angle on channel 3 never fires
    repeat (8) half(0);
    half(500);
    chk("drive_mid", 16'h0007, {12'h0, drive});
    wait_clk(400);
    chk("drive_late", 16'h0007, {12'h0, drive});
    wait_clk(85);
    chk("drive_cut", 16'h0000, {12'h0, drive});
    // large leads on channels 0 and 1, 60 clamps to 50
    angle = {4{8'h64}};
    wr(8'h14, 16'h0032);
    wr(8'h16, 16'h003C);
    half(0);
    half(400);
    chk("lead_early", 16'h000F, {12'h0, drive});
    wait_clk(200);
    chk("lead_cut", 16'h000C, {12'h0, drive});
    wr(8'h14, 16'h0005);
    wr(8'h16, 16'h0005);
    // digital: switching bits rule, angles ignored
    wr(8'h1C, 16'h0000);
    dig = 4'h5;
    half(0);
    half(500);
    chk("digital_on", 16'h0005, {12'h0, drive});
    dig = 4'h0;
    half(500);
    chk("digital_off", 16'h0000, {12'h0, drive});
    // suppression requested but frequency mode ignores it
    wr(8'h1C, 16'h001F);
    freq_mode = 1'b1;
    repeat (2) begin
      half(500);
      chk("freq_full_wave", 16'h000F, {12'h0, drive});
    end
    // offset codes on paired channels must never fire together
    for (int w = 0; w < 2; w++) begin
      wr(8'h20, pat[w]);
      half(0);
      cnt = '{0, 0, 0, 0};
      ov = 0;
      repeat (12) begin
        half(500);
        for (int c = 0; c < 4; c++) cnt[c] += int'(drive[c]);
        ov += int'(drive[1-w] & drive[3-w]);
      end
      for (int c = 0; c < 4; c++) chk("pattern_count", 16'(expc[w][c]), 16'(cnt[c]));
      chk("pattern_overlap", 16'h0000, 16'(ov));
    end
    // back in normal mode: pattern ignored, channel 0 loses negative halves
    freq_mode = 1'b0;
    repeat (3) begin
      half(500);
      chk("half_suppress", {12'h0, 3'h7, zc}, {12'h0, drive});
      chk("polarity", {15'h0, zc}, {15'h0, pol});
    end
    wr(8'h1C, 16'h000F);
    trip(8'h00, 4);
    trip(8'h80, 8);
    report_and_stop();
  end
endmodule // tb
